// ### eef_pkg.sv
// Package: offsets, flag bit positions and carrier structs of the flag bank
package eef_pkg;

    // Register addresses
    localparam logic [7:0] EEF_ADDR_BYTE2 = 8'hcd;
    localparam logic [7:0] EEF_ADDR_BYTE1 = 8'hce;
    localparam logic [7:0] EEF_ADDR_BYTE0 = 8'hcf;

    // Flag positions in the 16-bit implemented vector (byte1 above byte0)
    localparam int EEF_FB_SERIAL_OVF  = 0;
    localparam int EEF_FB_RADIO_OVF   = 1;
    localparam int EEF_FB_REG_WR_FAIL = 2;
    localparam int EEF_FB_ACK_MISSING = 3;
    localparam int EEF_FB_PAYLOAD_CRC = 4;
    localparam int EEF_FB_HEADER_CRC  = 5;
    localparam int EEF_FB_ACK_SEQ     = 6;
    localparam int EEF_FB_FRAME_TYPE  = 7;
    localparam int EEF_FB_TX_COMPLETE = 8;
    localparam int EEF_FB_RX_PENDING  = 9;
    localparam int EEF_FB_PLAIN_PKT   = 10;
    localparam int EEF_FB_SEQ_BACK    = 11;
    localparam int EEF_FB_SEQ_GAP     = 12;
    localparam int EEF_FB_PAIRING     = 13;

    // Implemented flag bits; bits 14 and 15 are reserved
    localparam int            EEF_FLAG_W     = 16;
    localparam logic [15:0]   EEF_FLAG_VALID = 16'h3fff;
    localparam logic [15:0]   EEF_FLAG_RESET = 16'h0000;
    localparam logic [7:0]    EEF_BYTE_ZERO  = 8'h00;
    localparam logic [7:0]    EEF_BYTE_ONES  = 8'hff;

    // Security option bit that admits unencrypted packets
    localparam int EEF_SEC_ACCEPT_PLAIN = 5;

    // Register access request from the command interface
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eef_req_s;

    // Event strobes from the packet, UART, security and join logic
    typedef struct packed {
        logic tx_sent;
        logic tx_ack_en;
        logic ack_rcvd;
        logic ack_gave_up;
        logic rx_waiting;
        logic plain_pkt;
        logic enc_pkt;
        logic join_start;
        logic serial_ovf;
        logic radio_ovf;
        logic reg_wr_fail;
        logic payload_crc_err;
        logic header_crc_err;
        logic ack_seq_err;
        logic frame_type_err;
    } eef_evt_s;

endpackage

// ### eef_flag_bank.sv
// Sticky flag bank: hardware set wins over host AND-clear and internal clear
`timescale 1ns/1ps
`default_nettype none
module eef_flag_bank
    import eef_pkg::*;
#(
    parameter int          W     = 16,
    parameter logic [15:0] VALID = 16'h3fff
) (
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    input  wire logic [W-1:0] keep_in,
    output var  logic [W-1:0] flags_out
);

    // Per-bit flags gathered on a net so every bit has a single driver
    wire logic [W-1:0] bits_w;

    // One flop per implemented bit, reserved bits tie low
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (VALID[i]) begin : g_flop
                logic flag_d;
                logic flag_q;
                assign flag_d = (flag_q & keep_in[i] & ~clr_in[i]) | set_in[i];
                always_ff @(posedge mclk_in or negedge rstn_in) begin
                    if (!rstn_in) begin
                        flag_q <= 1'b0;
                    end else begin
                        flag_q <= flag_d;
                    end
                end
                assign bits_w[i] = flag_q;
            end else begin : g_rsvd
                assign bits_w[i] = 1'b0;
            end
        end
    endgenerate

    assign flags_out = bits_w;

    // A flag raised in the clearing cycle survives
    a_set_wins_clear: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (set_in != '0) |=> ((flags_out & $past(set_in) & VALID[W-1:0]) ==
                            ($past(set_in) & VALID[W-1:0])))
        else $error("set flag lost");

endmodule
`default_nettype wire

// ### eef_seq_check.sv
// Sequence checker: compares each encrypted packet number with the last one
`timescale 1ns/1ps
`default_nettype none
module eef_seq_check
    import eef_pkg::*;
#(
    parameter int SEQ_W = 32
) (
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire logic             pkt_in,
    input  wire logic [SEQ_W-1:0] seq_in,
    output logic                  backward_out,
    output logic                  gap_out
);

    logic [SEQ_W-1:0] prev_q;
    logic             have_prev_q;
    logic [SEQ_W:0]   next_exp;

    // Widened so a wrap of prev plus one never looks like a gap
    assign next_exp     = {1'b0, prev_q} + {{SEQ_W{1'b0}}, 1'b1};
    assign backward_out = pkt_in & have_prev_q & (seq_in < prev_q);
    assign gap_out      = pkt_in & have_prev_q & ({1'b0, seq_in} > next_exp);

    // Remember the latest packet number
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_q      <= '0;
            have_prev_q <= 1'b0;
        end else if (pkt_in) begin
            prev_q      <= seq_in;
            have_prev_q <= 1'b1;
        end
    end

    a_seq_backward: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        pkt_in ##1 (pkt_in && seq_in < $past(seq_in)) |-> backward_out)
        else $error("smaller sequence number not flagged");

    a_seq_gap: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        pkt_in ##1 (pkt_in && {1'b0, seq_in} > {1'b0, $past(seq_in)} + 1)
        |-> (gap_out && !backward_out))
        else $error("sequence gap not flagged");

    c_seq_gap: cover property (@(posedge mclk_in) disable iff (!rstn_in) gap_out);

endmodule
`default_nettype wire

// ### eef_flags_top.sv
// Extended event flag bank: sticky flags, AND-write clear, status line
`timescale 1ns/1ps
`default_nettype none
module eef_flags_top
    import eef_pkg::*;
#(
    parameter int SEQ_W = 32
) (
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire eef_req_s         req_in,
    input  wire eef_evt_s         evt_in,
    input  wire logic [SEQ_W-1:0] enc_seq_in,
    input  wire logic [23:0]      ext_event_enable_mask_in,
    input  wire logic [7:0]       legacy_event_mask_in,
    input  wire logic [7:0]       security_options_in,
    output logic [7:0]            rdata_out,
    output logic                  rd_valid_out,
    output logic                  event_status_line_out
);

    // Flag vector and its set, clear and keep terms
    logic [EEF_FLAG_W-1:0] flags_q;
    logic [EEF_FLAG_W-1:0] set_vec;
    logic [EEF_FLAG_W-1:0] clr_vec;
    logic [EEF_FLAG_W-1:0] keep_vec;

    // Transmit acknowledgement tracking
    logic ack_wait_q;
    logic ack_wait_d;

    // Registered read path and status
    logic [7:0] rdata_d;
    logic       status_d;

    // Sequence checker results
    logic seq_back;
    logic seq_gap;

    // Address decode
    wire hit_b0 = (req_in.addr == EEF_ADDR_BYTE0);
    wire hit_b1 = (req_in.addr == EEF_ADDR_BYTE1);
    wire hit_b2 = (req_in.addr == EEF_ADDR_BYTE2);
    wire wr_b0  = req_in.wr & hit_b0;
    wire wr_b1  = req_in.wr & hit_b1;

    // Transmit-complete: direct, or held until the ack comes back
    wire tx_no_ack  = evt_in.tx_sent & ~evt_in.tx_ack_en;
    wire tx_ack_req = evt_in.tx_sent & evt_in.tx_ack_en;
    wire tx_acked   = ack_wait_q & evt_in.ack_rcvd;
    wire ack_end    = evt_in.ack_rcvd | evt_in.ack_gave_up;

    // A new acked send restarts the wait; ack or give-up ends it
    assign ack_wait_d = tx_ack_req ? 1'b1 : (ack_end ? 1'b0 : ack_wait_q);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_wait_q <= 1'b0;
        end else begin
            ack_wait_q <= ack_wait_d;
        end
    end

    // Plain packets only count while the option admits them
    wire plain_ok = security_options_in[EEF_SEC_ACCEPT_PLAIN];

    // Sequence comparison on encrypted packets
    eef_seq_check #(
        .SEQ_W (SEQ_W)
    ) u_seq (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .pkt_in       (evt_in.enc_pkt),
        .seq_in       (enc_seq_in),
        .backward_out (seq_back),
        .gap_out      (seq_gap)
    );

    // Event-to-flag mapping, least significant byte
    assign set_vec[EEF_FB_SERIAL_OVF]  = evt_in.serial_ovf;
    assign set_vec[EEF_FB_RADIO_OVF]   = evt_in.radio_ovf;
    assign set_vec[EEF_FB_REG_WR_FAIL] = evt_in.reg_wr_fail;
    assign set_vec[EEF_FB_ACK_MISSING] = evt_in.ack_gave_up;
    assign set_vec[EEF_FB_PAYLOAD_CRC] = evt_in.payload_crc_err;
    assign set_vec[EEF_FB_HEADER_CRC]  = evt_in.header_crc_err;
    assign set_vec[EEF_FB_ACK_SEQ]     = evt_in.ack_seq_err;
    assign set_vec[EEF_FB_FRAME_TYPE]  = evt_in.frame_type_err;

    // Event-to-flag mapping, byte 1
    assign set_vec[EEF_FB_TX_COMPLETE] = tx_no_ack | tx_acked;
    assign set_vec[EEF_FB_RX_PENDING]  = evt_in.rx_waiting;
    assign set_vec[EEF_FB_PLAIN_PKT]   = evt_in.plain_pkt & plain_ok;
    assign set_vec[EEF_FB_SEQ_BACK]    = seq_back;
    assign set_vec[EEF_FB_SEQ_GAP]     = seq_gap;
    assign set_vec[EEF_FB_PAIRING]     = evt_in.join_start;
    assign set_vec[15:14]              = 2'b00;

    // Receive-pending drops by itself once all bytes are gone
    assign clr_vec[EEF_FB_RX_PENDING]  = ~evt_in.rx_waiting;
    assign clr_vec[EEF_FB_RX_PENDING-1:0] = '0;
    assign clr_vec[EEF_FLAG_W-1:EEF_FB_RX_PENDING+1] = '0;

    // Host write ANDs its byte in; other bytes keep all ones
    assign keep_vec[7:0]  = wr_b0 ? req_in.wdata : EEF_BYTE_ONES;
    assign keep_vec[15:8] = wr_b1 ? req_in.wdata : EEF_BYTE_ONES;

    // Sticky storage; keep and clear only ever remove bits
    eef_flag_bank #(
        .W     (EEF_FLAG_W),
        .VALID (EEF_FLAG_VALID)
    ) u_bank (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .set_in    (set_vec),
        .clr_in    (clr_vec),
        .keep_in   (keep_vec),
        .flags_out (flags_q)
    );

    // Read mux; byte 2 and unmapped addresses return zero
    assign rdata_d = hit_b0 ? flags_q[7:0] :
                     hit_b1 ? (flags_q[15:8] & EEF_FLAG_VALID[15:8]) :
                     EEF_BYTE_ZERO;

    // Enabled flags drive the status line only with legacy mask zero
    wire [15:0] enabled_flags = flags_q & ext_event_enable_mask_in[15:0];
    wire        legacy_clear  = (legacy_event_mask_in == EEF_BYTE_ZERO);
    assign status_d = (|enabled_flags) & legacy_clear;

    // Output registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out             <= EEF_BYTE_ZERO;
            rd_valid_out          <= 1'b0;
            event_status_line_out <= 1'b0;
        end else begin
            rdata_out             <= req_in.rd ? rdata_d : rdata_out;
            rd_valid_out          <= req_in.rd;
            event_status_line_out <= status_d;
        end
    end

    // Checks on the flag bank behaviour
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_status_raise: assert property (
        ((|(flags_q & ext_event_enable_mask_in[15:0])) && legacy_event_mask_in == 8'h00)
        |=> event_status_line_out)
        else $error("status line not raised");

    a_status_drop: assert property (
        (!(|(flags_q & ext_event_enable_mask_in[15:0])) || legacy_event_mask_in != 8'h00)
        |=> !event_status_line_out)
        else $error("status line not dropped");

    a_read_stable: assert property (
        (req_in.rd && !req_in.wr && set_vec == 16'h0000 && evt_in.rx_waiting ==
         flags_q[EEF_FB_RX_PENDING]) |=> $stable(flags_q))
        else $error("read changed the flags");

    a_read_data: assert property (
        (req_in.rd && hit_b0) |=> (rd_valid_out && rdata_out == $past(flags_q[7:0])))
        else $error("read data mismatch");

    a_write_and: assert property (
        (wr_b0 && set_vec[7:0] == 8'h00) |=>
        flags_q[7:0] == ($past(flags_q[7:0]) & $past(req_in.wdata)))
        else $error("write did not AND into byte0");

    a_write_no_set: assert property (
        (req_in.wr && set_vec == 16'h0000) |=> ((flags_q & ~$past(flags_q)) == 16'h0000))
        else $error("host write set a flag");

    a_reserved_zero: assert property (
        (req_in.rd && (hit_b2 || hit_b1)) |=>
        (($past(hit_b2) && rdata_out == 8'h00) ||
        ($past(hit_b1) && rdata_out[7:6] == 2'b00)))
        else $error("reserved bits read nonzero");

    a_tx_wait_ack: assert property (
        (tx_ack_req && !flags_q[EEF_FB_TX_COMPLETE] && !ack_wait_q && !wr_b1) ##1
        (!evt_in.ack_rcvd && !evt_in.tx_sent) |-> !flags_q[EEF_FB_TX_COMPLETE])
        else $error("transmit flag set before ack");

    a_tx_acked: assert property (
        (ack_wait_q && evt_in.ack_rcvd) |=> flags_q[EEF_FB_TX_COMPLETE])
        else $error("ack did not set transmit flag");

    a_rx_follow: assert property (
        evt_in.rx_waiting ##1 !evt_in.rx_waiting |-> flags_q[EEF_FB_RX_PENDING] ##1
        !flags_q[EEF_FB_RX_PENDING])
        else $error("receive-pending flag does not follow bytes");

    a_plain_gate: assert property (
        (!flags_q[EEF_FB_PLAIN_PKT] && !security_options_in[5]) |=>
        !flags_q[EEF_FB_PLAIN_PKT])
        else $error("plain flag set while not accepted");

    a_pair_start: assert property (
        evt_in.join_start |=> flags_q[EEF_FB_PAIRING])
        else $error("pairing start not flagged");

    a_overflow: assert property (
        evt_in.serial_ovf |=> flags_q[EEF_FB_SERIAL_OVF])
        else $error("serial overflow not flagged");

    a_radio_ovf: assert property (
        evt_in.radio_ovf |=> flags_q[EEF_FB_RADIO_OVF])
        else $error("radio overflow not flagged");

    // Checks per event source, then byte1 write and read checks; a raised event shows on the next edge
    a_wr_fail_flag: assert property (
        evt_in.reg_wr_fail |=> flags_q[EEF_FB_REG_WR_FAIL])
        else $error("failed register write not flagged");

    a_ack_missing: assert property (
        evt_in.ack_gave_up |=> flags_q[EEF_FB_ACK_MISSING])
        else $error("missing ack not flagged");

    a_ack_wait_end: assert property (
        (evt_in.ack_gave_up && !tx_ack_req) |=> !ack_wait_q)
        else $error("ack wait survives the last retry");

    a_payload_crc: assert property (
        evt_in.payload_crc_err |=> flags_q[EEF_FB_PAYLOAD_CRC])
        else $error("payload check failure not flagged");

    a_header_crc: assert property (
        evt_in.header_crc_err |=> flags_q[EEF_FB_HEADER_CRC])
        else $error("header check failure not flagged");

    a_ack_seq_flag: assert property (
        evt_in.ack_seq_err |=> flags_q[EEF_FB_ACK_SEQ])
        else $error("wrong ack sequence id not flagged");

    a_frame_type: assert property (
        evt_in.frame_type_err |=> flags_q[EEF_FB_FRAME_TYPE])
        else $error("unsupported frame type not flagged");

    a_tx_direct: assert property (
        (evt_in.tx_sent && !evt_in.tx_ack_en) |=> flags_q[EEF_FB_TX_COMPLETE])
        else $error("unacked send not flagged");

    a_plain_accept: assert property (
        (evt_in.plain_pkt && security_options_in[EEF_SEC_ACCEPT_PLAIN])
        |=> flags_q[EEF_FB_PLAIN_PKT])
        else $error("accepted plain packet not flagged");

    a_seq_back_flag: assert property (
        seq_back |=> flags_q[EEF_FB_SEQ_BACK])
        else $error("backward sequence not flagged");

    a_seq_gap_flag: assert property (
        seq_gap |=> flags_q[EEF_FB_SEQ_GAP])
        else $error("sequence gap not flagged");

    a_rx_pending_set: assert property (
        evt_in.rx_waiting |=> flags_q[EEF_FB_RX_PENDING])
        else $error("waiting receive bytes not flagged");

    a_write_and_b1: assert property (
        (wr_b1 && set_vec[15:8] == 8'h00 && !flags_q[EEF_FB_RX_PENDING]) |=>
        flags_q[15:8] == ($past(flags_q[15:8]) & $past(req_in.wdata)))
        else $error("write did not AND into byte1");

    a_read_strobe: assert property (
        rd_valid_out == $past(req_in.rd))
        else $error("read answer strobe misplaced");

    a_read_data_b1: assert property (
        (req_in.rd && hit_b1) |=> (rdata_out == {2'b00, $past(flags_q[13:8])}))
        else $error("byte1 read data mismatch");

    // Main scenarios
    c_status_rise: cover property ($rose(event_status_line_out));
    c_clear_kept:  cover property (wr_b0 && set_vec[7:0] != 8'h00 && req_in.wdata == 8'h00);
    c_tx_acked:    cover property (tx_ack_req ##[1:20] tx_acked);
    c_rx_drain:    cover property ($fell(flags_q[EEF_FB_RX_PENDING]));

endmodule
`default_nettype wire

// ### eef_host_model.sv
// Host model: reads flag registers and clears serviced flags by AND-write
`timescale 1ns/1ps
`default_nettype none
module eef_host_model
    import eef_pkg::*;
(
    input  wire logic mclk_in,
    output var  eef_req_s req_out
);
    initial req_out = '0;
    // One-cycle request after a falling edge; released lines show inverse values
    task automatic access(input logic r, input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge mclk_in);
        req_out <= '{rd: r, wr: w, addr: a, wdata: d};
        @(negedge mclk_in);
        req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a);
        access(1'b1, 1'b0, a, 8'h5a);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        access(1'b0, 1'b1, a, d);
    endtask
    // Zeros only at serviced bits so unserviced flags survive
    task automatic service(input logic [7:0] a, input logic [7:0] done);
        access(1'b0, 1'b1, a, ~done);
    endtask
endmodule
`default_nettype wire

// ### extended_exception_flags_tb.sv
// Testbench: flag setting, AND-clear writes, reads and status line
`timescale 1ns/1ps
`default_nettype none
module extended_exception_flags_tb
    import eef_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        rstn_in = 1'b0;
    eef_req_s    req;
    eef_evt_s    evt_in;
    logic [31:0] enc_seq_in;
    logic [23:0] emask;
    logic [7:0]  lmask;
    logic [7:0]  sec;
    logic [7:0]  rdata_out;
    logic        rd_valid_out;
    logic        status;
    logic [15:0] exp_flags;
    logic [7:0]  rd_q[$];
    int          fails = 0;
    int          samples_checked = 0;
    int          seed = 66450;
    int          seqs[5] = '{5, 6, 6, 9, 2};
    int          sbit[5] = '{-1, -1, -1, EEF_FB_SEQ_GAP, EEF_FB_SEQ_BACK};

    always #25 mclk_in = ~mclk_in;

    eef_host_model i_host (.mclk_in(mclk_in), .req_out(req));
    eef_flags_top i_dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req), .evt_in(evt_in),
        .enc_seq_in(enc_seq_in), .ext_event_enable_mask_in(emask),
        .legacy_event_mask_in(lmask), .security_options_in(sec),
        .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
        .event_status_line_out(status)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] ex, input string what);
        samples_checked++;
        if (got !== ex) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, ex);
        end
    endtask
    function automatic logic [7:0] reg_of(input logic [7:0] a);
        case (a)
            8'hcf: return exp_flags[7:0];
            8'hce: return {2'b00, exp_flags[13:8]};
            default: return 8'h00;
        endcase
    endfunction
    // Note the expected byte, then let the host read it
    task automatic rreg(input logic [7:0] a);
        rd_q.push_back(reg_of(a));
        i_host.read_reg(a);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
        if (a == 8'hcf) exp_flags[7:0] &= d;
        if (a == 8'hce) exp_flags[13:8] &= d[5:0];
    endtask
    function automatic eef_evt_s ev(input int b);
        eef_evt_s e;
        e = '0;
        case (b)
            0: e.serial_ovf = 1'b1;
            1: e.radio_ovf = 1'b1;
            2: e.reg_wr_fail = 1'b1;
            4: e.payload_crc_err = 1'b1;
            5: e.header_crc_err = 1'b1;
            6: e.ack_seq_err = 1'b1;
            7: e.frame_type_err = 1'b1;
            13: e.join_start = 1'b1;
            default: e = '0;
        endcase
        return e;
    endfunction
    task automatic pulse(input eef_evt_s e, input logic [15:0] m);
        @(negedge mclk_in);
        evt_in <= e;
        @(negedge mclk_in);
        evt_in <= '0;
        exp_flags |= m;
    endtask
    task automatic chk_status;
        logic s;
        repeat (2) @(negedge mclk_in);
        s = (|(exp_flags & emask[15:0])) && (lmask == 8'h00);
        check({7'h0, status}, {7'h0, s}, "status");
    endtask
    task automatic final_report;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Read result monitor: every answer consumes the oldest note
    always @(negedge mclk_in) begin
        if (rd_valid_out === 1'b1) begin
            if (rd_q.size() == 0) begin
                fails++;
                $display("CHECK FAILED t=%0t unexpected read answer", $time);
            end else
                check(rdata_out, rd_q.pop_front(), "read");
        end
    end

    // Watchdog
    initial begin
        #(50 * 5000);
        fails++;
        $display("CHECK FAILED t=%0t timeout", $time);
        final_report();
    end

    // Main sequence
    initial begin
        evt_in = '0;
        enc_seq_in = '0;
        emask = '0;
        lmask = 8'h00;
        sec = 8'h00;
        exp_flags = '0;
        repeat (4) @(negedge mclk_in);
        rstn_in = 1'b1;
        foreach (seqs[i]) rreg(8'hcc + 8'(i));
        for (int b = 0; b < 14; b++) begin
            if (b inside {0, 1, 2, 4, 5, 6, 7, 13}) begin
                pulse(ev(b), 16'h1 << b);
                rreg(8'hcf);
                rreg(8'hce);
            end
        end
        wreg(8'hcf, 8'hff);
        wreg(8'hcd, 8'h00);
        rreg(8'hcd);
        wreg(8'hcf, 8'($random(seed)));
        rreg(8'hcf);
        i_host.service(8'hce, 8'h20);
        exp_flags[13] = 1'b0;
        rreg(8'hce);
        pulse('{plain_pkt: 1'b1, default: 1'b0}, 16'h0);
        sec = 8'h20;
        pulse('{plain_pkt: 1'b1, default: 1'b0}, 16'h0400);
        pulse('{tx_sent: 1'b1, default: 1'b0}, 16'h0100);
        rreg(8'hce);
        wreg(8'hce, 8'hfe);
        pulse('{tx_sent: 1'b1, tx_ack_en: 1'b1, default: 1'b0}, 16'h0);
        rreg(8'hce);
        pulse('{ack_rcvd: 1'b1, default: 1'b0}, 16'h0100);
        pulse('{tx_sent: 1'b1, tx_ack_en: 1'b1, default: 1'b0}, 16'h0);
        pulse('{ack_gave_up: 1'b1, default: 1'b0}, 16'h0008);
        rreg(8'hce);
        rreg(8'hcf);
        foreach (seqs[i]) begin
            enc_seq_in = 32'(seqs[i]);
            pulse('{enc_pkt: 1'b1, default: 1'b0}, sbit[i] < 0 ? 16'h0 : 16'h1 << sbit[i]);
            rreg(8'hce);
        end
        fork
            wreg(8'hcf, 8'h00);
            pulse(ev(0), 16'h0001);
        join
        exp_flags[7:0] = 8'h01;
        rreg(8'hcf);
        @(negedge mclk_in);
        evt_in.rx_waiting <= 1'b1;
        exp_flags[9] = 1'b1;
        rreg(8'hce);
        wreg(8'hce, 8'hfd);
        exp_flags[9] = 1'b1;
        rreg(8'hce);
        @(negedge mclk_in);
        evt_in.rx_waiting <= 1'b0;
        exp_flags[9] = 1'b0;
        rreg(8'hce);
        wreg(8'hcf, 8'h00);
        wreg(8'hce, 8'h00);
        emask = 24'h000001;
        chk_status();
        pulse(ev(0), 16'h0001);
        chk_status();
        lmask = 8'h01;
        chk_status();
        lmask = 8'h00;
        pulse(ev(1), 16'h0002);
        chk_status();
        wreg(8'hcf, 8'hfe);
        chk_status();
        emask = 24'($random(seed));
        chk_status();
        // Back-to-back encrypted packets 7, 9, 3: gap, gap, then backward
        @(negedge mclk_in);
        evt_in <= '{enc_pkt: 1'b1, default: 1'b0};
        enc_seq_in = 32'd7;
        @(negedge mclk_in);
        enc_seq_in = 32'd9;
        @(negedge mclk_in);
        enc_seq_in = 32'd3;
        @(negedge mclk_in);
        evt_in <= '0;
        exp_flags |= 16'h1800;
        rreg(8'hce);
        // Reset in mid-run drops every flag and the status line
        @(negedge mclk_in);
        rstn_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        rstn_in = 1'b1;
        exp_flags = '0;
        rreg(8'hce);
        rreg(8'hcf);
        chk_status();
        repeat (4) @(negedge mclk_in);
        check(8'(rd_q.size()), 8'h00, "reads left unanswered");
        final_report();
    end
endmodule
`default_nettype wire
